// ### hbm_defs.vh
`ifndef HBM_DEFS_VH
`define HBM_DEFS_VH

// timing: each waveform state dwells one interface wait
`define HBM_CLK_PERIOD_PS 20000
`define HBM_WAIT_PS 20830
`define HBM_DWELL_RAW (`HBM_WAIT_PS / `HBM_CLK_PERIOD_PS)
`define HBM_DWELL_CYC ((`HBM_DWELL_RAW < 1) ? 1 : `HBM_DWELL_RAW)

// waveform select codes
`define HBM_WF_FIRST 2'h0
`define HBM_WF_SECOND 2'h1
`define HBM_WF_READ 2'h2
`define HBM_WF_WRITE 2'h3

// bytes needed per port transfer
`define HBM_PAIR 2

// pin reset values
`define HBM_RST_RNW 1'h1
`define HBM_RST_STROBE_N 1'h1
`define HBM_RST_BHI 1'h0
`define HBM_RST_OE 1'h0
`define HBM_RST_DATA 8'h00
`define HBM_RST_SEL 2'h0
`define HBM_RST_COUNT 16'h0000

`endif

// ### hbm_master.v
// Function
// - each port access is two bytes; low half first, high half second
// - register writes use single waves; RAM data uses stream write/read waves
// - register write built from a first-byte wave and a second-byte wave
// - first-byte single write holds read_not_write low through S0 to S2
// - byte_half_indicator low in S0, one wait before strobe in S1
// - byte_half_indicator stays low through the active first-byte write
// - each state lasts one interface wait of at most 20.83 ns
// - single write drives its byte on the bus during strobe in S1
// - single write S2 releases strobe and returns to idle
// - second-byte single write as first, but byte_half_indicator high throughout
// - waveform_select picks which wave a single write start runs
// - stream write wave 3: S0 drives read_not_write and half indicator low
// - stream write S1 strobes and drives first outbound byte
// - stream write S2 pops fifo, releases strobe, raises half indicator
// - stream write S3 strobes again with second outbound byte
// - stream S5 loops to S0 until transaction_count expires, then idles
// - stream read wave 2 holds read_not_write high throughout
// - stream read S0 half indicator low, S1 strobes for first byte
// - read data is taken in S2, not S1, into inbound fifo
// - each read sample also advances the inbound fifo write side
// - stream read S2 raises half, S3 strobes, S4 samples second byte
// - control levels are settled before strobe falls, held till it rises
// - no new access starts while port_ready_n shows the port busy
// - register_select_lines driven for each access
`include "hbm_defs.vh"

module hbm_fifo #(
  parameter WIDTH = 8,
  parameter ADDR_W = 3,
  parameter DEPTH = 8
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire ce,
  // fill side
  input wire wr_valid,
  output reg wr_ready,
  input wire [WIDTH-1:0] wr_data,
  // drain side
  output reg rd_valid,
  input wire rd_ready,
  output reg [WIDTH-1:0] rd_data,
  // occupancy
  output reg [ADDR_W:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr;
  reg [ADDR_W-1:0] rd_ptr;
  wire do_wr;
  wire do_rd;
  wire [ADDR_W-1:0] next_rd_ptr;
  wire [ADDR_W:0] next_level;

  // pointer step, wraps at the pointer width
  function [ADDR_W-1:0] ptr_inc;
    input [ADDR_W-1:0] p;
    begin
      ptr_inc = p + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  assign do_wr = wr_valid & wr_ready;
  assign do_rd = rd_valid & rd_ready;
  assign next_rd_ptr = do_rd ? ptr_inc(rd_ptr) : rd_ptr;
  assign next_level = level + {{ADDR_W{1'b0}}, do_wr} - {{ADDR_W{1'b0}}, do_rd};

  always @(posedge clk) begin
    if (ce && do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= {ADDR_W{1'b0}};
      rd_ptr <= {ADDR_W{1'b0}};
      level <= {(ADDR_W+1){1'b0}};
      rd_valid <= 1'b0;
      wr_ready <= 1'b0;
      rd_data <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (do_wr) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      rd_ptr <= next_rd_ptr;
      level <= next_level;
      rd_valid <= (next_level != {(ADDR_W+1){1'b0}});
      wr_ready <= (next_level != DEPTH[ADDR_W:0]);
      // head word registered so the drain side sees a flop
      if (do_wr && (next_rd_ptr == wr_ptr)) begin
        rd_data <= wr_data;
      end else begin
        rd_data <= mem[next_rd_ptr];
      end
    end
  end
endmodule // hbm_fifo

module hbm_master #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter COUNT_W = 16
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire ce,
  // command
  input wire start,
  input wire [1:0] waveform_select,
  input wire [7:0] single_byte,
  input wire [1:0] reg_select,
  input wire [COUNT_W-1:0] transaction_count,
  output reg busy,
  // outbound byte stream
  input wire [7:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  // inbound byte stream
  output wire [7:0] rx_data,
  output wire rx_valid,
  input wire rx_ready,
  // port pins
  output reg [1:0] register_select_lines,
  output reg read_not_write,
  output reg port_data_strobe_n,
  output reg byte_half_indicator,
  output reg [7:0] port_data_out,
  output reg port_data_oe,
  input wire [7:0] port_data_in,
  input wire port_ready_n
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_S0 = 3'h1;
  localparam [2:0] ST_S1 = 3'h2;
  localparam [2:0] ST_S2 = 3'h3;
  localparam [2:0] ST_S3 = 3'h4;
  localparam [2:0] ST_S4 = 3'h5;
  localparam [2:0] ST_S5 = 3'h6;
  localparam integer DWELL_I = `HBM_DWELL_CYC;
  localparam integer PAIR_I = `HBM_PAIR;
  localparam [3:0] DWELL = DWELL_I[3:0];
  localparam [FIFO_AW:0] PAIR = PAIR_I[FIFO_AW:0];
  localparam [FIFO_AW:0] FREE_MAX = FIFO_DEPTH[FIFO_AW:0];
  localparam [COUNT_W-1:0] COUNT_ONE = {{(COUNT_W-1){1'b0}}, 1'b1};

  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] mode;
  reg [3:0] dwell;
  reg [COUNT_W-1:0] remaining;
  reg [7:0] single_hold;
  reg ready_s1;
  reg ready_s2;
  reg [7:0] din_s1;
  reg [7:0] din_s2;
  reg rx_push;
  reg tx_pop;
  wire [7:0] tx_head;
  wire tx_head_valid;
  wire [FIFO_AW:0] tx_level;
  wire [FIFO_AW:0] rx_level;
  wire rx_wr_ready;
  wire port_free;
  wire is_single;
  wire go_s0;
  reg [3:0] next_pins;

  // pin levels {rnw, strobe_n, half, oe} for a state of a wave
  function [3:0] pin_levels;
    input [2:0] st;
    input [1:0] wf;
    reg strobe;
    reg late;
    begin
      strobe = (st == ST_S1) || (st == ST_S3);
      late = (st == ST_S2) || (st == ST_S3) || (st == ST_S4) || (st == ST_S5);
      if (st == ST_IDLE) begin
        pin_levels = {1'b1, 1'b1, 1'b0, 1'b0};
      end else begin
        case (wf)
          `HBM_WF_FIRST: pin_levels = {1'b0, ~strobe, 1'b0,
                                       (st == ST_S1) || (st == ST_S2)};
          `HBM_WF_SECOND: pin_levels = {1'b0, ~strobe, 1'b1,
                                        (st == ST_S1) || (st == ST_S2)};
          `HBM_WF_WRITE: pin_levels = {1'b0, ~strobe, late,
                                       (st != ST_S0) && (st != ST_S5)};
          `HBM_WF_READ: pin_levels = {1'b1, ~strobe, late, 1'b0};
          default: pin_levels = {1'b1, 1'b1, 1'b0, 1'b0};
        endcase
      end
    end
  endfunction

  // outbound bytes in pairs, low half first
  hbm_fifo #(
    .WIDTH(8),
    .ADDR_W(FIFO_AW),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .wr_valid(tx_valid),
    .wr_ready(tx_ready),
    .wr_data(tx_data),
    .rd_valid(tx_head_valid),
    .rd_ready(tx_pop),
    .rd_data(tx_head),
    .level(tx_level)
  );

  // inbound bytes in pairs, low half first
  hbm_fifo #(
    .WIDTH(8),
    .ADDR_W(FIFO_AW),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .wr_valid(rx_push),
    .wr_ready(rx_wr_ready),
    .wr_data(din_s2),
    .rd_valid(rx_valid),
    .rd_ready(rx_ready),
    .rd_data(rx_data),
    .level(rx_level)
  );

  // pin inputs pass two flops
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_s1 <= 1'b0;
      ready_s2 <= 1'b0;
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
    end else if (ce) begin
      ready_s1 <= port_ready_n;
      ready_s2 <= ready_s1;
      din_s1 <= port_data_in;
      din_s2 <= din_s1;
    end
  end

  // high level on the ready pin means the port has finished its internal work
  // ready is seen two edges late, so a very short busy pulse can slip past
  assign port_free = ready_s2;
  assign is_single = (mode == `HBM_WF_FIRST) || (mode == `HBM_WF_SECOND);
  // stream waves wait for a whole pair so no half word goes out
  assign go_s0 = (dwell == 4'h0) && port_free &&
                 (is_single ||
                  ((mode == `HBM_WF_WRITE) && (tx_level >= PAIR)) ||
                  ((mode == `HBM_WF_READ) && ((FREE_MAX - rx_level) >= PAIR)));

  always @* begin
    next_state = state;
    tx_pop = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_S0;
        end
      end
      ST_S0: begin
        if (go_s0) begin
          next_state = ST_S1;
        end
      end
      ST_S1: begin
        if (dwell == 4'h0) begin
          next_state = ST_S2;
          // head advances as S2 begins, so S3 finds the second byte
          tx_pop = (mode == `HBM_WF_WRITE) && tx_head_valid;
        end
      end
      ST_S2: begin
        if (dwell == 4'h0) begin
          if (is_single) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_S3;
          end
        end
      end
      ST_S3: begin
        if (dwell == 4'h0) begin
          next_state = ST_S4;
          tx_pop = (mode == `HBM_WF_WRITE) && tx_head_valid;
        end
      end
      ST_S4: begin
        if (dwell == 4'h0) begin
          next_state = ST_S5;
        end
      end
      ST_S5: begin
        if (dwell == 4'h0) begin
          // a count of 0 or 1 runs one transfer
          if (remaining <= COUNT_ONE) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_S0;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @* begin
    if (state == ST_IDLE && start) begin
      next_pins = pin_levels(next_state, waveform_select);
    end else begin
      next_pins = pin_levels(next_state, mode);
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      mode <= `HBM_WF_FIRST;
      dwell <= 4'h0;
      remaining <= `HBM_RST_COUNT;
      single_hold <= `HBM_RST_DATA;
      rx_push <= 1'b0;
      busy <= 1'b0;
      register_select_lines <= `HBM_RST_SEL;
      read_not_write <= `HBM_RST_RNW;
      port_data_strobe_n <= `HBM_RST_STROBE_N;
      byte_half_indicator <= `HBM_RST_BHI;
      port_data_oe <= `HBM_RST_OE;
      port_data_out <= `HBM_RST_DATA;
    end else if (ce) begin
      state <= next_state;
      busy <= (next_state != ST_IDLE);
      if (next_state != state) begin
        dwell <= DWELL - 4'h1;
      end else if (dwell != 4'h0) begin
        dwell <= dwell - 4'h1;
      end
      if (state == ST_IDLE && start) begin
        mode <= waveform_select;
        single_hold <= single_byte;
        remaining <= transaction_count;
        register_select_lines <= reg_select;
      end else if (state == ST_S5 && next_state == ST_S0) begin
        remaining <= remaining - COUNT_ONE;
      end
      // synced bus holds the byte seen at the end of S1 or S3 one cycle later
      rx_push <= (mode == `HBM_WF_READ) && (dwell == 4'h0) &&
                 ((state == ST_S2) || (state == ST_S4)) && rx_wr_ready;
      read_not_write <= next_pins[3];
      port_data_strobe_n <= next_pins[2];
      byte_half_indicator <= next_pins[1];
      port_data_oe <= next_pins[0];
      // byte stays on the output between strobes; only the enable drops
      if (next_state == ST_S1 || next_state == ST_S3) begin
        if (state == ST_S0 && is_single) begin
          port_data_out <= single_hold;
        end else if (mode == `HBM_WF_WRITE) begin
          port_data_out <= tx_head;
        end
      end
    end
  end
endmodule // hbm_master

// ### hbm_port_model.sv
module hbm_port_model (
  // port pins
  input logic strobe_n,
  input logic rnw,
  input logic half,
  input logic [1:0] sel,
  input logic [7:0] data,
  output logic [7:0] data_in,
  output logic ready,
  // bench hold of ready
  input logic stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] log [$];
  logic [7:0] nxt = 8'hA0;
  assign ready = !stall;
  initial data_in = 8'h5A;
  // capture levels once the strobe edge settles
  always @(negedge strobe_n) begin
    #1;
    log.push_back({sel, rnw, half, rnw ? 8'h00 : data});
    if (rnw) begin
      #9 data_in = nxt;
      nxt = nxt + 8'h01;
    end
  end
  // released bus must not keep the old byte
  always @(posedge strobe_n) data_in = ~data_in;
endmodule // hbm_port_model

// ### hbm_master_chk.sv
module hbm_master_chk (
  // clock and reset
  input logic clk,
  input logic resetn,
  input logic ce,
  // command
  input logic start,
  input logic [1:0] waveform_select,
  input logic busy,
  // port pins
  input logic [1:0] register_select_lines,
  input logic read_not_write,
  input logic port_data_strobe_n,
  input logic byte_half_indicator,
  input logic port_data_oe,
  input logic port_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  idle_quiet_a: assert property (
    !busy |-> port_data_strobe_n && !port_data_oe) else $error("idle pins active");
  cmd_enter_a: assert property (
    !busy && start && ce |=> busy && port_data_strobe_n
    && byte_half_indicator == ($past(waveform_select) == 2'h1)) else $error("bad first state");
  strobe_pulse_a: assert property (
    $fell(port_data_strobe_n) && ce |=> port_data_strobe_n) else $error("strobe too long");
  data_drive_a: assert property (
    !port_data_strobe_n |-> port_data_oe == !read_not_write) else $error("bus drive wrong");
  ctrl_stable_a: assert property (
    $fell(port_data_strobe_n) |-> $stable(read_not_write) && $stable(byte_half_indicator)
    && $stable(register_select_lines)) else $error("levels not settled");
  dir_hold_a: assert property (
    busy && $past(busy) |-> $stable(read_not_write)) else $error("direction changed");
  ready_gate_a: assert property (
    !busy && !port_ready_n ##1 (busy && !port_ready_n) [*4] |=> port_data_strobe_n)
    else $error("no wait");
  read_pair_a: assert property (
    $fell(port_data_strobe_n) && read_not_write && byte_half_indicator
    |-> !$past(port_data_strobe_n, 2) && !$past(byte_half_indicator, 2))
    else $error("read pair order");
endmodule // hbm_master_chk

bind hbm_master hbm_master_chk u_hbm_master_chk (.clk(clk), .resetn(resetn), .ce(ce),
  .start(start), .waveform_select(waveform_select), .busy(busy),
  .register_select_lines(register_select_lines), .read_not_write(read_not_write),
  .port_data_strobe_n(port_data_strobe_n), .byte_half_indicator(byte_half_indicator),
  .port_data_oe(port_data_oe), .port_ready_n(port_ready_n));

// ### tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic [1:0] wf = 2'h0;
  logic [1:0] rsel = 2'h0;
  logic [7:0] sbyte = 8'h00;
  logic [15:0] cnt = 16'h0001;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic stall = 1'b0;
  logic ce = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic busy, tx_ready, rx_valid, rnw, stb_n, half, oe, prdy;
  logic [7:0] rx_data, pdo, pdi;
  logic [1:0] psel;
  int mismatches = 0;
  int n_tests = 0;
  int k, j;
  // rows: select, register, byte, expected capture
  logic [23:0] rows [4] = '{24'h0A50A5, 24'h4A51A5, 24'h13C43C, 24'h5C35C3};

  always #10 clk = ~clk;

  hbm_master u_hbm_master (.clk(clk), .resetn(resetn), .ce(ce), .start(start),
    .waveform_select(wf), .single_byte(sbyte), .reg_select(rsel), .transaction_count(cnt),
    .busy(busy), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .register_select_lines(psel), .read_not_write(rnw), .port_data_strobe_n(stb_n),
    .byte_half_indicator(half), .port_data_out(pdo), .port_data_oe(oe),
    .port_data_in(pdi), .port_ready_n(prdy));
  hbm_port_model u_hbm_port_model (.strobe_n(stb_n), .rnw(rnw), .half(half), .sel(psel),
    .data(pdo), .data_in(pdi), .ready(prdy), .stall(stall));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic logchk(input logic [11:0] exp);
    if (u_hbm_port_model.log.size() == 0) chk(12'hFFF, exp);
    else chk(u_hbm_port_model.log.pop_front(), exp);
  endtask

  task automatic issue(input logic [1:0] w, input logic [1:0] s, input logic [7:0] b,
                       input logic [15:0] c);
    @(negedge clk);
    wf = w;
    rsel = s;
    sbyte = b;
    cnt = c;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) begin
      mismatches++;
      stop_test();
    end
  endtask

  initial begin
    repeat (8) @(negedge clk);
    chk({psel, rnw, stb_n, half, oe, busy, tx_ready, rx_valid, 3'h0}, 12'h300);
    resetn = 1'b1;
    $display("reset test done");
    foreach (rows[r]) begin
      issue(rows[r][23:22], rows[r][21:20], rows[r][19:12], 16'h0001);
      wait_idle();
      logchk(rows[r][11:0]);
      chk(12'(u_hbm_port_model.log.size()), 12'h000);
    end
    $display("single write rows done");
    tx_valid = 1'b1;
    for (k = 0, j = 0; k < 8 && j < 60; j++) begin
      tx_data = 8'h10 + k[7:0];
      if (tx_ready === 1'b1) k++;
      @(negedge clk);
    end
    tx_valid = 1'b0;
    if (k < 8) begin
      mismatches++;
      stop_test();
    end
    chk({11'h0, tx_ready}, 12'h000);
    issue(2'h3, 2'h2, 8'h00, 16'h0004);
    wait_idle();
    for (k = 0; k < 8; k++) logchk({3'h4, k[0], 8'h10 + k[7:0]});
    chk(12'(u_hbm_port_model.log.size()), 12'h000);
    $display("stream write done");
    issue(2'h2, 2'h2, 8'h00, 16'h0003);
    wait_idle();
    for (k = 0; k < 6; k++) logchk({3'h5, k[0], 8'h00});
    rx_ready = 1'b1;
    for (k = 0, j = 0; k < 6 && j < 60; j++) begin
      if (rx_valid === 1'b1) begin
        chk({4'h0, rx_data}, {4'h0, 8'hA0 + k[7:0]});
        k++;
      end
      @(negedge clk);
    end
    if (k < 6) begin
      mismatches++;
      stop_test();
    end
    chk({11'h0, rx_valid}, 12'h000);
    $display("stream read done");
    stall = 1'b1;
    issue(2'h0, 2'h1, 8'h77, 16'h0001);
    repeat (6) @(negedge clk);
    chk(12'(u_hbm_port_model.log.size()), 12'h000);
    stall = 1'b0;
    wait_idle();
    logchk(12'h477);
    $display("ready stall done");
    issue(2'h1, 2'h3, 8'h5A, 16'h0001);
    ce = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h00, busy, rnw, stb_n, half, oe}, 12'h016);
    chk(12'(u_hbm_port_model.log.size()), 12'h000);
    ce = 1'b1;
    wait_idle();
    logchk(12'hD5A);
    $display("clock enable freeze done");
    issue(2'h3, 2'h0, 8'h00, 16'h0001);
    repeat (3) @(negedge clk);
    chk({11'h0, busy}, 12'h001);
    chk(12'(u_hbm_port_model.log.size()), 12'h000);
    resetn = 1'b0;
    @(negedge clk);
    chk({psel, rnw, stb_n, half, oe, busy, tx_ready, rx_valid, 3'h0}, 12'h300);
    resetn = 1'b1;
    @(negedge clk);
    chk({10'h0, busy, tx_ready}, 12'h001);
    issue(2'h0, 2'h2, 8'h3C, 16'h0001);
    wait_idle();
    logchk(12'h83C);
    chk(12'(u_hbm_port_model.log.size()), 12'h000);
    $display("mid-run reset done");
    stop_test();
  end
endmodule // tb
